// ---- src/dfqa_pkg.sv ----
package dfqa_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_FIFO_HIGH = 8'h06;
	localparam logic [7:0] IDX_FIFO_LOW  = 8'h07;
	localparam logic [7:0] IDX_CMPA_EXT  = 8'h08;
	localparam logic [7:0] IDX_FIFO_EXT  = 8'h0C;
	localparam logic [7:0] IDX_CMPA_ADDR = 8'h0D;
	localparam logic [7:0] IDX_CTRL      = 8'h0E;
	localparam logic [7:0] IDX_STATUS    = 8'h0F;

	localparam int unsigned ADDR_W  = 12;
	localparam int unsigned DATA_W  = 32;
	localparam int unsigned IDX_LSB = 2;

	// comparator a extension fields
	localparam int unsigned EXT_DIR_EN  = 7;
	localparam int unsigned EXT_DIR_VAL = 6;
	localparam int unsigned EXT_PAGE    = 5;
	localparam int unsigned EXT_BIT16   = 0;
	localparam logic [7:0]  EXT_MASK    = 8'hE1;

	// control fields
	localparam int unsigned CTRL_ON    = 0;
	localparam int unsigned CTRL_BEGIN = 1;
	localparam int unsigned CTRL_EVENT = 2;
	localparam logic [7:0]  CTRL_MASK  = 8'h07;

	// status fields
	localparam int unsigned STAT_CNT_LSB = 0;
	localparam int unsigned STAT_EMPTY   = 4;
	localparam int unsigned STAT_FULL    = 5;
	localparam int unsigned STAT_MATCH   = 6;

	// trace fifo
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned PTR_W      = 3;
	localparam int unsigned CNT_W      = 4;
	localparam int unsigned WORD_W     = 24;

	localparam logic [7:0]        RST_BYTE = 8'h00;
	localparam logic [15:0]       RST_HALF = 16'h0000;
	localparam logic [WORD_W-1:0] RST_WORD = 24'h000000;
	localparam logic [PTR_W-1:0]  PTR_ONE  = 3'h1;
	localparam logic [CNT_W-1:0]  CNT_ONE  = 4'h1;
	localparam logic [CNT_W-1:0]  CNT_FULL = 4'h8;

endpackage : dfqa_pkg

// ---- src/dfqa_cmp_if.sv ----
`timescale 1ns/100ps
interface dfqa_cmp_if;
	logic [7:0]  ext;
	logic [15:0] cmp_addr;
	logic        bus_valid;
	logic        bus_rd;
	logic [15:0] bus_addr;
	logic [2:0]  page;
	logic        paged_sel;
	logic        lap_sel;
	logic [16:0] lap_addr;
	logic [16:0] addr17;
	logic        match;

	modport ctrl (
		output ext, cmp_addr, bus_valid, bus_rd, bus_addr, page,
		output paged_sel, lap_sel, lap_addr,
		input  addr17, match
	);
	modport cmp (
		input  ext, cmp_addr, bus_valid, bus_rd, bus_addr, page,
		input  paged_sel, lap_sel, lap_addr,
		output addr17, match
	);
endinterface : dfqa_cmp_if

// ---- src/dfqa_cmpa.sv ----
`timescale 1ns/100ps
module dfqa_cmpa (
	dfqa_cmp_if.cmp c
);
	wire dir_ok;
	wire page_ok;
	wire b16_ok;
	wire low_ok;

	// paged form addresses flash through the page bits
	assign c.addr17 = c.paged_sel ? {c.page, c.bus_addr[13:0]} :
		(c.lap_sel ? c.lap_addr : {1'b0, c.bus_addr});

	// direction ignored unless enabled; value 1 means read
	assign dir_ok = ~c.ext[dfqa_pkg::EXT_DIR_EN] |
		(c.bus_rd == c.ext[dfqa_pkg::EXT_DIR_VAL]);
	assign page_ok = c.paged_sel == c.ext[dfqa_pkg::EXT_PAGE];
	assign b16_ok  = c.addr17[16] == c.ext[dfqa_pkg::EXT_BIT16];
	assign low_ok  = c.addr17[15:0] == c.cmp_addr;

	assign c.match = c.bus_valid & dir_ok & page_ok & b16_ok & low_ok;
endmodule : dfqa_cmpa

// ---- src/dfqa_top.sv ----
// Function
// - low-byte register returns bits 7..0 of the current fifo word
// - reading the low byte moves the fifo read pointer on
// - event-only modes: entries may be read by low byte alone
// - clear on any reset except end-trace with module on, begin clear
// - extension bit 7 enables direction qualification of comparator a
// - extension bit 6: 0 matches writes, 1 matches reads
// - extension bit 5 must equal the paged-access indicator
// - paged access compares page bits above address bits 13..0
// - unpaged compares zero-extended address or linear pointer value
// - extension bit 0 is compared against address bit 16
// - high-byte register returns bits 15..8 of the current word
`timescale 1ns/100ps
module dfqa_top (
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        end_trace_rst_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// monitored core bus
	input  wire logic        core_valid_i,
	input  wire logic        core_rd_i,
	input  wire logic [15:0] core_addr_i,
	input  wire logic [7:0]  core_data_i,
	input  wire logic [2:0]  ppage_i,
	input  wire logic        paged_sel_i,
	input  wire logic        lap_sel_i,
	input  wire logic [16:0] lap_addr_i,
	// debug event
	output logic             cmpa_match_o
);

	function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
		hit = (a[11:dfqa_pkg::IDX_LSB] == {2'b00, idx})
			&& (a[dfqa_pkg::IDX_LSB-1:0] == 2'b00);
	endfunction : hit

	dfqa_cmp_if cif ();

	// state
	logic [7:0]  ext_q;
	logic [7:0]  ext_d;
	logic [15:0] caddr_q;
	logic [15:0] caddr_d;
	logic [7:0]  ctrl_q;
	logic [7:0]  ctrl_d;
	logic [dfqa_pkg::WORD_W-1:0] mem_q [dfqa_pkg::FIFO_DEPTH];
	logic [dfqa_pkg::PTR_W-1:0]  wptr_q;
	logic [dfqa_pkg::PTR_W-1:0]  wptr_d;
	logic [dfqa_pkg::PTR_W-1:0]  rptr_q;
	logic [dfqa_pkg::PTR_W-1:0]  rptr_d;
	logic [dfqa_pkg::CNT_W-1:0]  cnt_q;
	logic [dfqa_pkg::CNT_W-1:0]  cnt_d;
	logic [31:0] prdata_d;
	logic        pready_d;
	logic        pslverr_d;
	logic        match_d;

	// bus decode
	wire acc       = psel_i & penable_i & ~pready_o;
	wire sel_high  = hit(paddr_i, dfqa_pkg::IDX_FIFO_HIGH);
	wire sel_low   = hit(paddr_i, dfqa_pkg::IDX_FIFO_LOW);
	wire sel_ext   = hit(paddr_i, dfqa_pkg::IDX_CMPA_EXT);
	wire sel_fext  = hit(paddr_i, dfqa_pkg::IDX_FIFO_EXT);
	wire sel_caddr = hit(paddr_i, dfqa_pkg::IDX_CMPA_ADDR);
	wire sel_ctrl  = hit(paddr_i, dfqa_pkg::IDX_CTRL);
	wire sel_stat  = hit(paddr_i, dfqa_pkg::IDX_STATUS);
	wire mapped    = sel_high | sel_low | sel_ext | sel_fext | sel_caddr
		| sel_ctrl | sel_stat;
	wire wr        = acc & pwrite_i & mapped;
	wire rd        = acc & ~pwrite_i & mapped;

	// fifo status
	wire empty = cnt_q == '0;
	wire full  = cnt_q == dfqa_pkg::CNT_FULL;
	wire on    = ctrl_q[dfqa_pkg::CTRL_ON];
	wire evmode = ctrl_q[dfqa_pkg::CTRL_EVENT];
	wire [dfqa_pkg::WORD_W-1:0] cur_word = mem_q[rptr_q];

	// only the low-byte read pops; a write to it is ignored
	wire pop  = rd & sel_low & ~empty;
	// full fifo drops new captures; stored history is kept intact
	wire push = on & cif.match & ~full;

	// event-only entries carry the data byte, upper bytes read zero
	wire [dfqa_pkg::WORD_W-1:0] cap_word = evmode ?
		{dfqa_pkg::RST_HALF, core_data_i} :
		{7'h00, cif.addr17};

	// retention across an end-trace reset
	wire keep = end_trace_rst_i & on & ~ctrl_q[dfqa_pkg::CTRL_BEGIN];
	wire clr  = ~rst_b_i & ~keep;
	wire hold = ~rst_b_i & keep;

	// comparator hookup
	assign cif.ext       = ext_q;
	assign cif.cmp_addr  = caddr_q;
	assign cif.bus_valid = core_valid_i;
	assign cif.bus_rd    = core_rd_i;
	assign cif.bus_addr  = core_addr_i;
	assign cif.page      = ppage_i;
	assign cif.paged_sel = paged_sel_i;
	assign cif.lap_sel   = lap_sel_i;
	assign cif.lap_addr  = lap_addr_i;

	dfqa_cmpa u_cmpa (
		.c (cif.cmp)
	);

	// register writes
	assign ext_d = (wr & sel_ext) ?
		(pwdata_i[7:0] & dfqa_pkg::EXT_MASK) : ext_q;
	assign caddr_d = (wr & sel_caddr) ? pwdata_i[15:0] : caddr_q;
	assign ctrl_d  = (wr & sel_ctrl) ?
		(pwdata_i[7:0] & dfqa_pkg::CTRL_MASK) : ctrl_q;

	// pointers
	assign wptr_d = push ? wptr_q + dfqa_pkg::PTR_ONE : wptr_q;
	assign rptr_d = pop ? rptr_q + dfqa_pkg::PTR_ONE : rptr_q;
	assign cnt_d  = (push & ~pop) ? cnt_q + dfqa_pkg::CNT_ONE :
		(pop & ~push) ? cnt_q - dfqa_pkg::CNT_ONE : cnt_q;

	// read data; reserved bits and upper lanes are zero
	always_comb begin
		prdata_d = '0;
		if (sel_low) begin
			prdata_d[7:0] = cur_word[7:0];
		end else if (sel_high) begin
			prdata_d[7:0] = cur_word[15:8];
		end else if (sel_fext) begin
			prdata_d[7:0] = cur_word[23:16];
		end else if (sel_ext) begin
			prdata_d[7:0] = ext_q & dfqa_pkg::EXT_MASK;
		end else if (sel_caddr) begin
			prdata_d[15:0] = caddr_q;
		end else if (sel_ctrl) begin
			prdata_d[7:0] = ctrl_q;
		end else if (sel_stat) begin
			prdata_d[dfqa_pkg::STAT_CNT_LSB +: dfqa_pkg::CNT_W] = cnt_q;
			prdata_d[dfqa_pkg::STAT_EMPTY] = empty;
			prdata_d[dfqa_pkg::STAT_FULL]  = full;
			prdata_d[dfqa_pkg::STAT_MATCH] = cmpa_match_o;
		end
	end

	// one wait state: ready rises one cycle into the access phase
	assign pready_d  = acc;
	assign pslverr_d = acc & ~mapped;
	assign match_d   = on & cif.match;

	// bus answer flops clear on every reset kind
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			prdata_o  <= '0;
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			prdata_o  <= (~pwrite_i & acc) ? prdata_d : '0;
			pready_o  <= pready_d;
			pslverr_o <= pslverr_d;
		end
	end

	// retained registers
	always_ff @(posedge sys_clk_i) begin
		if (clr) begin
			ext_q   <= dfqa_pkg::RST_BYTE;
			caddr_q <= dfqa_pkg::RST_HALF;
			ctrl_q  <= dfqa_pkg::RST_BYTE;
			wptr_q  <= '0;
			rptr_q  <= '0;
			cnt_q   <= '0;
		end else if (!hold) begin
			ext_q   <= ext_d;
			caddr_q <= caddr_d;
			ctrl_q  <= ctrl_d;
			wptr_q  <= wptr_d;
			rptr_q  <= rptr_d;
			cnt_q   <= cnt_d;
		end
	end

	// fifo storage; reading yields zero until written after a clear
	always_ff @(posedge sys_clk_i) begin
		for (int i = 0; i < dfqa_pkg::FIFO_DEPTH; i++) begin
			if (clr) begin
				mem_q[i] <= dfqa_pkg::RST_WORD;
			end else if (!hold && push && wptr_q == i[dfqa_pkg::PTR_W-1:0]) begin
				mem_q[i] <= cap_word;
			end
		end
	end

	// match event output
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			cmpa_match_o <= 1'b0;
		end else begin
			cmpa_match_o <= match_d;
		end
	end

endmodule : dfqa_top

// ---- tb/dfqa_monitor.sv ----
`timescale 1ns/100ps
module dfqa_monitor (
	// clock and reset
	input wire logic        sys_clk_i,
	input wire logic        rst_b_i,
	// apb
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	// core bus
	input wire logic        core_valid_i,
	input wire logic        cmpa_match_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_access;
		psel_i && penable_i && !pready_o;
	endsequence
	a_one_wait: assert property (s_access |=> pready_o)
		else $error("ready not one cycle after access");
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	a_ready_cause: assert property (
		pready_o |-> $past(psel_i && penable_i))
		else $error("ready without access");
	a_idle_zero: assert property (!pready_o |-> prdata_o == 32'h0)
		else $error("read data outside answer");
	a_err_ready: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	a_misalign_err: assert property (
		pready_o && $past(paddr_i[1:0]) != 2'h0 |-> pslverr_o)
		else $error("misaligned access not refused");
	a_upper_zero: assert property (
		pready_o && $past(paddr_i) != 12'h034 |-> prdata_o[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_match_valid: assert property (
		cmpa_match_o |-> $past(core_valid_i))
		else $error("match without core cycle");
endmodule : dfqa_monitor

// ---- tb/dfqa_core_model.sv ----
`timescale 1ns/100ps
module dfqa_core_model (
	// clock and command
	input  wire logic        clk_i,
	input  wire logic        go_i,
	input  wire logic [29:0] cmd_i,
	// core bus
	output logic             valid_o,
	output logic [29:0]      bus_o,
	output logic [16:0]      lap_o
);
	assign lap_o = 17'h11234;
	initial valid_o = 1'b0;
	initial bus_o = 30'h0;
	// lines are not held after a cycle, so stale values cannot fake a match
	always @(posedge clk_i) begin
		valid_o <= go_i;
		bus_o <= go_i ? cmd_i : ~bus_o;
	end
endmodule : dfqa_core_model

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
module testbench;
	logic sys_clk_i = 0, rst_b_i = 0, end_trace_rst_i = 0;
	logic psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o;
	logic [11:0] paddr_i = 0;
	logic [31:0] pwdata_i = 0, prdata_o, rdv, erv;
	logic core_valid_i, core_rd_i, paged_sel_i, lap_sel_i, cmpa_match_o;
	logic [15:0] core_addr_i;
	logic [7:0]  core_data_i;
	logic [2:0]  ppage_i;
	logic [16:0] lap_addr_i;
	logic go = 0;
	logic [1:0] lo = 2'h0;
	logic [29:0] cmd = 0;
	logic [30:0] r;
	int fail_count = 0, n_checks = 0;
	// ext, {rd, paged, lap select, expected}, page, address
	localparam logic [30:0] ROWS [12] = '{
		{8'h00, 4'h1, 3'h0, 16'h1234}, {8'h01, 4'h0, 3'h0, 16'h1234},
		{8'h01, 4'h3, 3'h0, 16'h1234}, {8'h00, 4'h2, 3'h0, 16'h1234},
		{8'h80, 4'h1, 3'h0, 16'h1234}, {8'h80, 4'h8, 3'h0, 16'h1234},
		{8'hC0, 4'h9, 3'h0, 16'h1234}, {8'h40, 4'h9, 3'h0, 16'h1234},
		{8'h20, 4'h5, 3'h0, 16'hD234}, {8'h00, 4'h4, 3'h0, 16'hD234},
		{8'h21, 4'h5, 3'h4, 16'hD234}, {8'h20, 4'h0, 3'h0, 16'h1234}};
	always #2.5 sys_clk_i = ~sys_clk_i;
	dfqa_top dut (.sys_clk_i, .rst_b_i, .end_trace_rst_i, .psel_i,
		.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
		.pslverr_o, .core_valid_i, .core_rd_i, .core_addr_i, .core_data_i,
		.ppage_i, .paged_sel_i, .lap_sel_i, .lap_addr_i, .cmpa_match_o);
	dfqa_core_model partner (.clk_i(sys_clk_i), .go_i(go), .cmd_i(cmd),
		.valid_o(core_valid_i), .lap_o(lap_addr_i), .bus_o({core_rd_i,
		paged_sel_i, lap_sel_i, ppage_i, core_addr_i, core_data_i}));
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task chk_match(input logic e);
		n_checks++;
		if (cmpa_match_o !== e) begin
			fail_count++;
			$display("MISMATCH %0t match %b want %b", $time, cmpa_match_o, e);
		end
	endtask : chk_match
	task apb(input logic w, input logic [7:0] i, input logic [31:0] d);
		@(posedge sys_clk_i);
		{psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, 2'h0, i, lo, d};
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		// no local limit: only the watchdog ends a hung transfer
		do begin
			@(posedge sys_clk_i);
		end while (pready_o !== 1'b1);
		rdv = prdata_o;
		erv = {31'h0, pslverr_o};
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task core(input logic [29:0] c);
		@(posedge sys_clk_i);
		{go, cmd} <= {1'b1, c};
		@(posedge sys_clk_i);
		go <= 1'b0;
		@(posedge sys_clk_i);
		@(negedge sys_clk_i);
	endtask : core
	task rst(input logic et);
		@(posedge sys_clk_i);
		{rst_b_i, end_trace_rst_i} <= {1'b0, et};
		repeat (3) @(posedge sys_clk_i);
		{rst_b_i, end_trace_rst_i} <= 2'b10;
	endtask : rst
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		#20000;
		fail_count++;
		give_verdict();
	end
	initial begin
		rst(1'b0);
		apb(1'b1, dfqa_pkg::IDX_CMPA_ADDR, 32'h1234);
		apb(1'b1, dfqa_pkg::IDX_CTRL, 32'h1);
		apb(1'b1, dfqa_pkg::IDX_CMPA_EXT, 32'hFF);
		apb(1'b0, dfqa_pkg::IDX_CMPA_EXT, 32'h0);
		chk(rdv, 32'hE1);
		// misaligned write must be refused and leave the register alone
		lo = 2'h1;
		apb(1'b1, dfqa_pkg::IDX_CMPA_EXT, 32'h00);
		lo = 2'h0;
		chk(erv, 32'h1);
		apb(1'b0, dfqa_pkg::IDX_CMPA_EXT, 32'h0);
		chk(rdv, 32'hE1);
		for (int i = 0; i < 12; i++) begin
			r = ROWS[i];
			apb(1'b1, dfqa_pkg::IDX_CMPA_EXT, {24'h0, r[30:23]});
			core({r[22:20], r[18:0], 8'h00});
			chk_match(r[19]);
		end
		apb(1'b0, 8'h01, 32'h0);
		chk(erv, 32'h1);
		apb(1'b1, dfqa_pkg::IDX_CMPA_EXT, 32'hA1);
		rst(1'b1);
		apb(1'b0, dfqa_pkg::IDX_CMPA_EXT, 32'h0);
		chk(rdv, 32'hA1);
		rst(1'b0);
		apb(1'b0, dfqa_pkg::IDX_CMPA_EXT, 32'h0);
		chk(rdv, 32'h0);
		apb(1'b1, dfqa_pkg::IDX_CMPA_ADDR, 32'h1234);
		apb(1'b1, dfqa_pkg::IDX_CTRL, 32'h5);
		core({6'h0, 16'h1234, 8'h5A});
		core({6'h0, 16'h1234, 8'hA5});
		apb(1'b0, dfqa_pkg::IDX_FIFO_LOW, 32'h0);
		chk(rdv, 32'h5A);
		apb(1'b1, dfqa_pkg::IDX_FIFO_LOW, 32'hFF);
		apb(1'b0, dfqa_pkg::IDX_FIFO_LOW, 32'h0);
		chk(rdv, 32'hA5);
		rst(1'b0);
		apb(1'b1, dfqa_pkg::IDX_CMPA_ADDR, 32'h1234);
		apb(1'b1, dfqa_pkg::IDX_CTRL, 32'h1);
		core({6'h0, 16'h1234, 8'h77});
		apb(1'b0, dfqa_pkg::IDX_FIFO_EXT, 32'h0);
		chk(rdv, 32'h0);
		apb(1'b0, dfqa_pkg::IDX_FIFO_HIGH, 32'h0);
		chk(rdv, 32'h12);
		apb(1'b0, dfqa_pkg::IDX_FIFO_LOW, 32'h0);
		chk(rdv, 32'h34);
		give_verdict();
	end
endmodule : testbench
bind dfqa_top dfqa_monitor mon (.sys_clk_i, .rst_b_i, .psel_i, .penable_i,
	.paddr_i, .prdata_o, .pready_o, .pslverr_o, .core_valid_i, .cmpa_match_o);
